// *** rtl/sec_ctrl_pkg.sv ***
package sec_ctrl_pkg;
	// coprocessor move encoding
	localparam logic [2:0] OPC1_SEL = 3'h0;
	localparam logic [3:0] CRN_SEL = 4'h1;
	localparam logic [3:0] CRM_SEL = 4'h1;
	localparam logic [2:0] OPC2_NSAC = 3'h2;
	localparam logic [2:0] OPC2_MOVR = 3'h3;
	localparam logic [3:0] CRN_PRELOAD = 4'hb;
	localparam logic [3:0] CRN_LOCKDOWN = 4'ha;
	localparam logic [3:0] CRM_LOCKDOWN = 4'h0;
	localparam logic [2:0] OPC2_LOCKDOWN = 3'h0;
	// field positions of nonsecure_access_ctrl
	localparam int NSAC_COH_POS = 18;
	localparam int NSAC_LOCK_POS = 17;
	localparam int NSAC_PRE_POS = 16;
	localparam int NSAC_SIMD_POS = 15;
	localparam int NSAC_UFP_POS = 14;
	localparam int NSAC_FP_COPROC_B_NONSECURE_ALLOW_POS = 11;
	localparam int NSAC_FP_COPROC_A_NONSECURE_ALLOW_POS = 10;
	// field positions of mask_override_ctrl
	localparam int MOVR_ABT_POS = 8;
	localparam int MOVR_IRQ_POS = 7;
	localparam int MOVR_FIQ_POS = 6;
	// writable masks and reset values
	localparam logic [31:0] NSAC_WMASK = 32'h0007_cc00;
	localparam logic [31:0] MOVR_WMASK = 32'h0000_01c0;
	localparam logic [31:0] NSAC_RESET = 32'h0000_0000;
	localparam logic [31:0] MOVR_RESET = 32'h0000_0000;
	// coherency bit position inside the auxiliary control word
	localparam int AUX_COH_POS = 6;
	localparam logic [31:0] AUX_RESET = 32'h0000_0000;
	// simd and upper fp disables inside coproc_access_ctrl
	localparam int CPAC_SIMD_POS = 31;
	localparam int CPAC_UFP_POS = 30;
	localparam logic [1:0] CPAC_RESET = 2'h0;
	// coprocessor numbers gated by the fp allow bits
	localparam logic [3:0] CP_NUM_FPA = 4'ha;
	localparam logic [3:0] CP_NUM_FPB = 4'hb;
	// system-control and debug coprocessor numbers, control-group encodings
	localparam logic [3:0] CP_NUM_SYS = 4'hf;
	localparam logic [3:0] CP_NUM_DBG = 4'he;
	localparam logic [3:0] CRM_C0 = 4'h0;
	localparam logic [2:0] OPC2_AUX = 3'h1;
	localparam logic [2:0] OPC2_CPAC = 3'h2;
endpackage

// *** rtl/sec_reg_word.sv ***
`timescale 1ns/100ps
// one masked software register
module sec_reg_word #(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] RESET_VAL = '0,
	parameter logic [WIDTH-1:0] WMASK = '1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0] value
);
	logic [WIDTH-1:0] value_r;
	logic [WIDTH-1:0] value_nxt;

	assign value_nxt = wr_en ? ((value_r & ~WMASK) | (wr_data & WMASK)) : value_r;
	assign value = value_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			value_r <= RESET_VAL;
		else
			value_r <= value_nxt;
	end
endmodule

// *** rtl/irq_override.sv ***
`timescale 1ns/100ps
// one exception line: take it when unmasked or forced past its mask
module irq_override (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pending,
	input wire logic psw_mask,
	input wire logic nonsecure,
	input wire logic route_bit,
	input wire logic override_bit,
	output logic take
);
	logic take_r;
	logic take_nxt;
	logic forced;

	// override only counts in non-secure state with routing set
	assign forced = nonsecure & route_bit & override_bit;
	assign take_nxt = pending & (~psw_mask | forced);
	assign take = take_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			take_r <= 1'b0;
		else
			take_r <= take_nxt;
	end
endmodule

// *** rtl/sec_access_ctrl.sv ***
`timescale 1ns/100ps
// How it works
// - access register: privileged only; secure reads/writes, non-secure reads only
// - debug coprocessor access never gated by this register; system-control coprocessor gated only at aux, preload and lockdown
// - access register bits 31:19, 13:12, 9:0 reserved, written zero, read zero
// - coherency allow clear: non-secure aux write undefined, coherency bit kept
// - coherency allow set: non-secure aux write updates only coherency bit
// - bit 17 allows lockable translation entries in non-secure state; reset forbids
// - preload allow clear: non-secure preload group access trapped undefined
// - preload allow set: non-secure preload group access permitted
// - without preload engine, preload allow reads zero, writes ignored
// - simd force set: simd disable reads one non-secure, writes ignored
// - upper fp force set: upper fp disable reads one non-secure, writes ignored
// - bit 11: zero secure-only coprocessor 11, one both states
// - bit 10 sets non-secure permission for coprocessor 10
// - access register decoded at opcode1 0, c1, c1, opcode2 2
// - override register: privileged and secure only
// - abort override forces async abort past mask in non-secure with routing
// - irq override forces irq past mask in non-secure with routing
// - fiq override forces fiq past mask in non-secure with routing
// - override register bits 31:9 and 5:0 reserved, read zero
// - override register decoded at opcode1 0, c1, c1, opcode2 3
// - simd disable one makes non-fp simd instructions undefined
// - lockable allow zero denies non-secure lockdown register access
module sec_access_ctrl
	import sec_ctrl_pkg::*;
#(
	parameter bit HAS_PRELOAD = 1'b1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	// coprocessor move request, same clock domain
	input wire logic mov_valid,
	input wire logic mov_write,
	input wire logic [3:0] mov_cp_num,
	input wire logic [2:0] mov_opc1,
	input wire logic [3:0] mov_crn,
	input wire logic [3:0] mov_crm,
	input wire logic [2:0] mov_opc2,
	input wire logic [31:0] mov_wdata,
	input wire logic mov_privileged,
	input wire logic mov_nonsecure,
	output logic [31:0] mov_rdata,
	output logic mov_done,
	output logic mov_undef,
	// instruction class checks
	input wire logic simd_only_insn,
	output logic simd_insn_undef,
	// security routing state
	input wire logic external_abort_route_bit,
	input wire logic irq_route_bit,
	input wire logic fiq_route_bit,
	input wire logic [2:0] psw_mask_aif,
	input wire logic async_abort_pending,
	input wire logic irq_pending,
	input wire logic fiq_pending,
	output logic take_async_abort,
	output logic take_irq,
	output logic take_fiq,
	// resource outputs
	output logic coherency_participation_bit,
	output logic simd_disable_bit,
	output logic upper_fp_regs_disable,
	output logic ns_lockable_alloc_ok
);
	import sec_ctrl_pkg::*;

	logic [31:0] nsac_q;
	logic [31:0] movr_q;
	logic [31:0] nsac_wmask_eff;
	logic [31:0] rdata_r, rdata_nxt;
	logic done_r, undef_r, simd_undef_r, lock_ok_r;
	logic coh_r, coh_nxt;
	logic [1:0] cpac_r, cpac_nxt;

	// decode
	wire logic is_system_control_coprocessor = mov_valid && mov_cp_num == CP_NUM_SYS && mov_opc1 == OPC1_SEL;
	wire logic sel_c1c1 = is_system_control_coprocessor && mov_crn == CRN_SEL && mov_crm == CRM_SEL;
	wire logic sel_nsac = sel_c1c1 && mov_opc2 == OPC2_NSAC;
	wire logic sel_movr = sel_c1c1 && mov_opc2 == OPC2_MOVR;
	wire logic sel_aux = is_system_control_coprocessor && mov_crn == CRN_SEL && mov_crm == CRM_C0
		&& mov_opc2 == OPC2_AUX;
	wire logic sel_cpac = is_system_control_coprocessor && mov_crn == CRN_SEL && mov_crm == CRM_C0
		&& mov_opc2 == OPC2_CPAC;
	wire logic sel_pre = is_system_control_coprocessor && mov_crn == CRN_PRELOAD;
	wire logic sel_lock = is_system_control_coprocessor && mov_crn == CRN_LOCKDOWN && mov_crm == CRM_LOCKDOWN
		&& mov_opc2 == OPC2_LOCKDOWN;
	wire logic sel_fpa = mov_valid && mov_cp_num == CP_NUM_FPA;
	wire logic sel_fpb = mov_valid && mov_cp_num == CP_NUM_FPB;

	wire logic ns = mov_nonsecure;
	wire logic pre_allow = HAS_PRELOAD && nsac_q[NSAC_PRE_POS];

	// permission checks
	wire logic nsac_bad = sel_nsac && (!mov_privileged || (ns && mov_write));
	wire logic movr_bad = sel_movr && (!mov_privileged || ns);
	wire logic aux_bad = sel_aux && ns && mov_write && !nsac_q[NSAC_COH_POS];
	wire logic pre_bad = sel_pre && ns && !pre_allow;
	wire logic lock_bad = sel_lock && ns && !nsac_q[NSAC_LOCK_POS];
	wire logic fpa_bad = sel_fpa && ns && !nsac_q[NSAC_FP_COPROC_A_NONSECURE_ALLOW_POS];
	wire logic fpb_bad = sel_fpb && ns && !nsac_q[NSAC_FP_COPROC_B_NONSECURE_ALLOW_POS];
	// debug coprocessor is not gated here; system-control coprocessor only at the nsac, movr, aux, preload and lockdown selects
	wire logic any_bad = nsac_bad | movr_bad | aux_bad | pre_bad | lock_bad
		| fpa_bad | fpb_bad;

	// no preload engine: its allow bit is not writable at all
	assign nsac_wmask_eff = HAS_PRELOAD ? NSAC_WMASK
		: (NSAC_WMASK & ~(32'h1 << NSAC_PRE_POS));
	wire logic nsac_we = sel_nsac && mov_write && !nsac_bad;
	wire logic movr_we = sel_movr && mov_write && !movr_bad;

	sec_reg_word #(
		.WIDTH(32),
		.RESET_VAL(NSAC_RESET),
		.WMASK(NSAC_WMASK)
	) u_nsac (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wr_en(nsac_we),
		.wr_data(mov_wdata & nsac_wmask_eff),
		.value(nsac_q)
	);

	sec_reg_word #(
		.WIDTH(32),
		.RESET_VAL(MOVR_RESET),
		.WMASK(MOVR_WMASK)
	) u_movr (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wr_en(movr_we),
		.wr_data(mov_wdata),
		.value(movr_q)
	);

	// auxiliary coherency bit: non-secure writes touch only that bit
	wire logic aux_we = sel_aux && mov_write && mov_privileged && !aux_bad;
	assign coh_nxt = aux_we ? mov_wdata[AUX_COH_POS] : coh_r;

	// simd / upper fp disables; forced to one for non-secure reads and the simd undef check when forcing set, not at the disable outputs
	wire logic simd_force = nsac_q[NSAC_SIMD_POS];
	wire logic ufp_force = nsac_q[NSAC_UFP_POS];
	wire logic cpac_we = sel_cpac && mov_write && mov_privileged;
	always_comb
	begin
		cpac_nxt = cpac_r;
		if (cpac_we && !(ns && simd_force))
			cpac_nxt[1] = mov_wdata[CPAC_SIMD_POS];
		if (cpac_we && !(ns && ufp_force))
			cpac_nxt[0] = mov_wdata[CPAC_UFP_POS];
	end
	wire logic simd_eff = cpac_r[1] | (ns & simd_force);
	wire logic ufp_eff = cpac_r[0] | (ns & ufp_force);

	// read mux; reserved bits read zero
	always_comb
	begin
		rdata_nxt = 32'h0;
		if (sel_nsac)
			rdata_nxt = nsac_q & nsac_wmask_eff;
		else if (sel_movr)
			rdata_nxt = movr_q & MOVR_WMASK;
		else if (sel_aux)
			rdata_nxt[AUX_COH_POS] = coh_r;
		else if (sel_cpac)
		begin
			rdata_nxt[CPAC_SIMD_POS] = simd_eff;
			rdata_nxt[CPAC_UFP_POS] = ufp_eff;
		end
		if (any_bad || mov_write)
			rdata_nxt = 32'h0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_r <= 32'h0;
			done_r <= 1'b0;
			undef_r <= 1'b0;
			coh_r <= 1'b0;
			cpac_r <= CPAC_RESET;
			simd_undef_r <= 1'b0;
			lock_ok_r <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			done_r <= mov_valid;
			undef_r <= any_bad;
			coh_r <= coh_nxt;
			cpac_r <= cpac_nxt;
			simd_undef_r <= simd_only_insn && simd_eff;
			lock_ok_r <= nsac_q[NSAC_LOCK_POS];
		end
	end

	irq_override u_abt (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pending(async_abort_pending),
		.psw_mask(psw_mask_aif[2]),
		.nonsecure(ns),
		.route_bit(external_abort_route_bit),
		.override_bit(movr_q[MOVR_ABT_POS]),
		.take(take_async_abort)
	);
	irq_override u_irq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pending(irq_pending),
		.psw_mask(psw_mask_aif[1]),
		.nonsecure(ns),
		.route_bit(irq_route_bit),
		.override_bit(movr_q[MOVR_IRQ_POS]),
		.take(take_irq)
	);
	irq_override u_fiq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pending(fiq_pending),
		.psw_mask(psw_mask_aif[0]),
		.nonsecure(ns),
		.route_bit(fiq_route_bit),
		.override_bit(movr_q[MOVR_FIQ_POS]),
		.take(take_fiq)
	);

	assign mov_rdata = rdata_r;
	assign mov_done = done_r;
	assign mov_undef = undef_r;
	assign coherency_participation_bit = coh_r;
	assign simd_disable_bit = cpac_r[1];
	assign upper_fp_regs_disable = cpac_r[0];
	assign simd_insn_undef = simd_undef_r;
	assign ns_lockable_alloc_ok = lock_ok_r;

	a_ns_write_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_nsac && mov_write && ns |=> $stable(nsac_q))
		else $error("non-secure write changed access register");
	a_movr_secure_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_movr && ns |=> mov_undef && $stable(movr_q))
		else $error("non-secure override register access not refused");
	a_nsac_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_nsac && !mov_write |=> (mov_rdata & ~NSAC_WMASK) == 32'h0)
		else $error("reserved access bits read nonzero");
	a_aux_undef: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_aux && ns && mov_write && !nsac_q[NSAC_COH_POS] |=> mov_undef && $stable(coh_r))
		else $error("non-secure aux write not trapped");
	a_preload_trap: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_pre && ns && !nsac_q[NSAC_PRE_POS] |=> mov_undef)
		else $error("non-secure preload access not trapped");
	a_fp_coproc_b_nonsecure_allow_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_fpb && ns |=> mov_undef == !$past(nsac_q[NSAC_FP_COPROC_B_NONSECURE_ALLOW_POS]))
		else $error("coprocessor 11 gate wrong");
	a_simd_forced: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_cpac && !mov_write && ns && simd_force |=> mov_rdata[CPAC_SIMD_POS])
		else $error("forced simd disable read zero");
	a_irq_override: assert property (@(posedge clk_sys) disable iff (!rst_n)
		irq_pending && psw_mask_aif[1] && ns && irq_route_bit && movr_q[MOVR_IRQ_POS]
		|=> take_irq)
		else $error("irq override not honoured");
	a_fiq_secure: assert property (@(posedge clk_sys) disable iff (!rst_n)
		fiq_pending && psw_mask_aif[0] && !ns |=> !take_fiq)
		else $error("fiq taken past mask in secure state");
	a_simd_undef: assert property (@(posedge clk_sys) disable iff (!rst_n)
		simd_only_insn && simd_eff |=> simd_insn_undef)
		else $error("simd-only instruction not undefined");

	// further guards on the move path and on exception forcing
	a_nsac_user_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_nsac && !mov_privileged |=> mov_undef && $stable(nsac_q))
		else $error("user access register access not refused");
	a_nsac_priv_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_nsac && !mov_write && mov_privileged
		|=> !mov_undef && mov_rdata == ($past(nsac_q) & nsac_wmask_eff))
		else $error("privileged access register read wrong");
	a_debug_ungated: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mov_valid && mov_cp_num == CP_NUM_DBG |=> !mov_undef)
		else $error("debug coprocessor access refused");
	a_coh_permit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_aux && ns && mov_write && mov_privileged && nsac_q[NSAC_COH_POS]
		|=> !mov_undef && coherency_participation_bit == $past(mov_wdata[AUX_COH_POS]))
		else $error("permitted coherency write not applied");
	a_preload_permit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_pre && ns && pre_allow |=> !mov_undef)
		else $error("permitted preload access refused");
	a_preload_absent: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!HAS_PRELOAD && sel_nsac && !mov_write |=> !mov_rdata[NSAC_PRE_POS])
		else $error("absent preload allow bit read one");
	a_ufp_forced: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_cpac && !mov_write && ns && ufp_force |=> mov_rdata[CPAC_UFP_POS])
		else $error("forced upper fp disable read zero");
	a_simd_wr_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cpac_we && ns && simd_force |=> $stable(simd_disable_bit))
		else $error("forced simd disable was written");
	a_ufp_wr_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cpac_we && ns && ufp_force |=> $stable(upper_fp_regs_disable))
		else $error("forced upper fp disable was written");
	a_fp_coproc_a_nonsecure_allow_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_fpa && ns |=> mov_undef == !$past(nsac_q[NSAC_FP_COPROC_A_NONSECURE_ALLOW_POS]))
		else $error("coprocessor 10 gate wrong");
	a_fp_coproc_b_nonsecure_allow_secure: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_fpb && !ns |=> !mov_undef)
		else $error("secure coprocessor 11 access refused");
	a_decode_opc1: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mov_valid && mov_cp_num == CP_NUM_SYS && mov_opc1 != OPC1_SEL
		|=> !mov_undef && mov_rdata == 32'h0)
		else $error("wrong opcode1 decoded as a register");
	a_movr_user: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_movr && !mov_privileged |=> mov_undef && $stable(movr_q))
		else $error("user override register access not refused");
	a_abort_override: assert property (@(posedge clk_sys) disable iff (!rst_n)
		async_abort_pending && psw_mask_aif[2] && ns && external_abort_route_bit
		&& movr_q[MOVR_ABT_POS] |=> take_async_abort)
		else $error("abort override not honoured");
	a_abort_secure: assert property (@(posedge clk_sys) disable iff (!rst_n)
		async_abort_pending && psw_mask_aif[2] && !ns |=> !take_async_abort)
		else $error("abort taken past mask in secure state");
	a_abort_noroute: assert property (@(posedge clk_sys) disable iff (!rst_n)
		async_abort_pending && psw_mask_aif[2] && !external_abort_route_bit |=> !take_async_abort)
		else $error("abort taken past mask without routing");
	a_irq_secure: assert property (@(posedge clk_sys) disable iff (!rst_n)
		irq_pending && psw_mask_aif[1] && !ns |=> !take_irq)
		else $error("irq taken past mask in secure state");
	a_irq_noroute: assert property (@(posedge clk_sys) disable iff (!rst_n)
		irq_pending && psw_mask_aif[1] && !irq_route_bit |=> !take_irq)
		else $error("irq taken past mask without routing");
	a_fiq_override: assert property (@(posedge clk_sys) disable iff (!rst_n)
		fiq_pending && psw_mask_aif[0] && ns && fiq_route_bit
		&& movr_q[MOVR_FIQ_POS] |=> take_fiq)
		else $error("fiq override not honoured");
	a_fiq_noroute: assert property (@(posedge clk_sys) disable iff (!rst_n)
		fiq_pending && psw_mask_aif[0] && !fiq_route_bit |=> !take_fiq)
		else $error("fiq taken past mask without routing");
	a_movr_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_movr && !mov_write |=> (mov_rdata & ~MOVR_WMASK) == 32'h0)
		else $error("reserved override bits read nonzero");
	a_lockdown_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sel_lock && ns && !nsac_q[NSAC_LOCK_POS] |=> mov_undef)
		else $error("non-secure lockdown access not refused");
	a_refused_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		any_bad |=> mov_rdata == 32'h0)
		else $error("refused access returned data");
endmodule

// *** sim/nonsecure_access_and_mask_override_bench.sv ***
`timescale 1ns/100ps
module nonsecure_access_and_mask_override_bench;
	import sec_ctrl_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic mov_valid = 1'b0, mov_write = 1'b0, mov_privileged = 1'b0, mov_nonsecure = 1'b0;
	logic [3:0] mov_cp_num = 4'h0, mov_crn = 4'h0, mov_crm = 4'h0;
	logic [2:0] mov_opc1 = 3'h0, mov_opc2 = 3'h0, psw_mask_aif = 3'h0;
	logic [31:0] mov_wdata = 32'h0;
	logic simd_only_insn = 1'b0, external_abort_route_bit = 1'b0;
	logic irq_route_bit = 1'b0, fiq_route_bit = 1'b0;
	logic async_abort_pending = 1'b0, irq_pending = 1'b0, fiq_pending = 1'b0;
	logic [31:0] mov_rdata;
	logic mov_done, mov_undef, simd_insn_undef, take_async_abort, take_irq, take_fiq;
	logic coherency_participation_bit, simd_disable_bit, upper_fp_regs_disable;
	logic ns_lockable_alloc_ok;
	logic [31:0] rd;
	logic un, dn;
	logic [31:0] np_rdata, np_rd;
	logic np_undef, np_un;
	int error_cnt = 0;
	int checked = 0;

	sec_access_ctrl uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .mov_valid(mov_valid), .mov_write(mov_write),
		.mov_cp_num(mov_cp_num), .mov_opc1(mov_opc1), .mov_crn(mov_crn), .mov_crm(mov_crm),
		.mov_opc2(mov_opc2), .mov_wdata(mov_wdata), .mov_privileged(mov_privileged),
		.mov_nonsecure(mov_nonsecure), .mov_rdata(mov_rdata), .mov_done(mov_done),
		.mov_undef(mov_undef), .simd_only_insn(simd_only_insn),
		.simd_insn_undef(simd_insn_undef),
		.external_abort_route_bit(external_abort_route_bit), .irq_route_bit(irq_route_bit),
		.fiq_route_bit(fiq_route_bit), .psw_mask_aif(psw_mask_aif),
		.async_abort_pending(async_abort_pending), .irq_pending(irq_pending),
		.fiq_pending(fiq_pending), .take_async_abort(take_async_abort), .take_irq(take_irq),
		.take_fiq(take_fiq), .coherency_participation_bit(coherency_participation_bit),
		.simd_disable_bit(simd_disable_bit), .upper_fp_regs_disable(upper_fp_regs_disable),
		.ns_lockable_alloc_ok(ns_lockable_alloc_ok)
	);

	// second copy built without a preload engine, fed the same requests
	sec_access_ctrl #(.HAS_PRELOAD(1'b0)) uut_np (
		.clk_sys(clk_sys), .rst_n(rst_n), .mov_valid(mov_valid), .mov_write(mov_write),
		.mov_cp_num(mov_cp_num), .mov_opc1(mov_opc1), .mov_crn(mov_crn), .mov_crm(mov_crm),
		.mov_opc2(mov_opc2), .mov_wdata(mov_wdata), .mov_privileged(mov_privileged),
		.mov_nonsecure(mov_nonsecure), .mov_rdata(np_rdata), .mov_done(),
		.mov_undef(np_undef), .simd_only_insn(simd_only_insn), .simd_insn_undef(),
		.external_abort_route_bit(external_abort_route_bit), .irq_route_bit(irq_route_bit),
		.fiq_route_bit(fiq_route_bit), .psw_mask_aif(psw_mask_aif),
		.async_abort_pending(async_abort_pending), .irq_pending(irq_pending),
		.fiq_pending(fiq_pending), .take_async_abort(), .take_irq(), .take_fiq(),
		.coherency_participation_bit(), .simd_disable_bit(), .upper_fp_regs_disable(),
		.ns_lockable_alloc_ok()
	);

	always #4 clk_sys = ~clk_sys;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one request, held across one sampling edge; the answer stands the following cycle
	task automatic mv(input logic w, input logic [3:0] cp, crn, crm, input logic [2:0] o2,
		input logic [31:0] wd, input logic pr, ns);
		@(negedge clk_sys);
		mov_valid = 1'b1;
		mov_write = w;
		mov_cp_num = cp;
		mov_crn = crn;
		mov_crm = crm;
		mov_opc2 = o2;
		mov_wdata = wd;
		mov_privileged = pr;
		mov_nonsecure = ns;
		@(negedge clk_sys);
		mov_valid = 1'b0;
		rd = mov_rdata;
		un = mov_undef;
		dn = mov_done;
		np_rd = np_rdata;
		np_un = np_undef;
	endtask

	// privileged non-secure access, judged only on refusal
	task automatic probe(input string nm, input logic [3:0] cp, crn, crm,
		input logic [2:0] o2, input logic w, input logic e);
		mv(w, cp, crn, crm, o2, 32'hffff_ffff, 1'b1, 1'b1);
		chk(nm, {31'h0, e}, {31'h0, un});
	endtask

	task automatic ov(input string nm, input logic [2:0] m, r, input logic ns,
		input logic [2:0] e);
		@(negedge clk_sys);
		psw_mask_aif = m;
		{external_abort_route_bit, irq_route_bit, fiq_route_bit} = r;
		mov_nonsecure = ns;
		{async_abort_pending, irq_pending, fiq_pending} = 3'h7;
		@(negedge clk_sys);
		chk(nm, {29'h0, e}, {29'h0, take_async_abort, take_irq, take_fiq});
	endtask

	task automatic t_reset;
		mv(1'b0, 4'hf, CRN_SEL, CRM_SEL, OPC2_NSAC, 32'h0, 1'b1, 1'b0);
		chk("nsac reset", NSAC_RESET, rd);
		chk("lock reset", 32'h0, {31'h0, ns_lockable_alloc_ok});
		mv(1'b0, 4'hf, CRN_SEL, CRM_SEL, OPC2_MOVR, 32'h0, 1'b1, 1'b0);
		chk("movr reset", MOVR_RESET, rd);
	endtask

	// all controls clear: every gated non-secure access refused
	task automatic t_refused;
		probe("aux ns wr", 4'hf, 4'h1, 4'h0, 3'h1, 1'b1, 1'b1);
		chk("coh kept", 32'h0, {31'h0, coherency_participation_bit});
		probe("c11 ns", 4'hf, CRN_PRELOAD, 4'h0, 3'h0, 1'b0, 1'b1);
		probe("fp_coproc_a_nonsecure_allow ns", CP_NUM_FPA, 4'h0, 4'h0, 3'h0, 1'b0, 1'b1);
		probe("fp_coproc_b_nonsecure_allow ns", CP_NUM_FPB, 4'h0, 4'h0, 3'h0, 1'b0, 1'b1);
		probe("lockdn ns", 4'hf, CRN_LOCKDOWN, CRM_LOCKDOWN, OPC2_LOCKDOWN, 1'b0, 1'b1);
		probe("movr ns rd", 4'hf, CRN_SEL, CRM_SEL, OPC2_MOVR, 1'b0, 1'b1);
		mv(1'b0, 4'hf, CRN_SEL, CRM_SEL, OPC2_MOVR, 32'h0, 1'b0, 1'b0);
		chk("movr user", 32'h1, {31'h0, un});
		mv(1'b0, 4'hf, CRN_SEL, CRM_SEL, OPC2_NSAC, 32'h0, 1'b0, 1'b0);
		chk("nsac user", 32'h1, {31'h0, un});
		probe("dbg ns", CP_NUM_DBG, 4'h0, 4'h0, 3'h0, 1'b1, 1'b0);
		probe("sysctl ns0", 4'hf, 4'h1, 4'h0, 3'h0, 1'b0, 1'b0);
	endtask

	task automatic t_nsac;
		mv(1'b1, 4'hf, CRN_SEL, CRM_SEL, OPC2_NSAC, 32'hffff_ffff, 1'b1, 1'b0);
		chk("nsac wr ok", 32'h2, {30'h0, dn, un});
		probe("nsac ns wr", 4'hf, CRN_SEL, CRM_SEL, OPC2_NSAC, 1'b1, 1'b1);
		mv(1'b0, 4'hf, CRN_SEL, CRM_SEL, OPC2_NSAC, 32'h0, 1'b1, 1'b1);
		chk("nsac ns rd", 32'h0007_cc00, rd);
		chk("np nsac rd", 32'h0006_cc00, np_rd);
		chk("lock set", 32'h1, {31'h0, ns_lockable_alloc_ok});
		mov_opc1 = 3'h1;
		mv(1'b0, 4'hf, CRN_SEL, CRM_SEL, OPC2_NSAC, 32'h0, 1'b1, 1'b0);
		mov_opc1 = OPC1_SEL;
		chk("nsac opc1", 32'h0, rd);
		mv(1'b0, 4'hf, CRN_SEL, 4'h2, OPC2_NSAC, 32'h0, 1'b1, 1'b0);
		chk("nsac crm", 32'h0, rd);
		mv(1'b0, 4'hf, CRN_SEL, CRM_SEL, 3'h4, 32'h0, 1'b1, 1'b0);
		chk("nsac opc2", 32'h0, rd);
	endtask

	task automatic t_permit;
		probe("aux ns wr", 4'hf, 4'h1, 4'h0, 3'h1, 1'b1, 1'b0);
		chk("coh set", 32'h1, {31'h0, coherency_participation_bit});
		probe("c11 ns", 4'hf, CRN_PRELOAD, 4'h0, 3'h0, 1'b0, 1'b0);
		chk("np c11 ns", 32'h1, {31'h0, np_un});
		probe("fp_coproc_a_nonsecure_allow ns", CP_NUM_FPA, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
		probe("fp_coproc_b_nonsecure_allow ns", CP_NUM_FPB, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
		probe("lockdn ns", 4'hf, CRN_LOCKDOWN, CRM_LOCKDOWN, OPC2_LOCKDOWN, 1'b0, 1'b0);
		probe("sysctl ns", 4'hf, 4'h1, 4'h0, 3'h0, 1'b0, 1'b0);
	endtask

	// forces show only to non-secure readers; stored bits stay as secure wrote them
	task automatic t_force;
		mv(1'b1, 4'hf, 4'h1, 4'h0, 3'h2, 32'h0, 1'b1, 1'b0);
		mv(1'b0, 4'hf, 4'h1, 4'h0, 3'h2, 32'h0, 1'b1, 1'b1);
		chk("cpac ns", 32'h3, {30'h0, rd[CPAC_SIMD_POS], rd[CPAC_UFP_POS]});
		mv(1'b0, 4'hf, 4'h1, 4'h0, 3'h2, 32'h0, 1'b1, 1'b0);
		chk("cpac s", 32'h0, {30'h0, rd[CPAC_SIMD_POS], rd[CPAC_UFP_POS]});
		simd_only_insn = 1'b1;
		@(negedge clk_sys);
		chk("simd s", 32'h0, {31'h0, simd_insn_undef});
		mov_nonsecure = 1'b1;
		@(negedge clk_sys);
		@(negedge clk_sys);
		chk("simd ns", 32'h1, {31'h0, simd_insn_undef});
		simd_only_insn = 1'b0;
		mv(1'b1, 4'hf, 4'h1, 4'h0, 3'h2, 32'hffff_ffff, 1'b1, 1'b1);
		chk("cpac ns wr", 32'h0, {30'h0, simd_disable_bit, upper_fp_regs_disable});
		mv(1'b1, 4'hf, 4'h1, 4'h0, 3'h2, 32'hc000_0000, 1'b1, 1'b0);
		chk("cpac s wr", 32'h3, {30'h0, simd_disable_bit, upper_fp_regs_disable});
	endtask

	task automatic t_movr;
		ov("ovr off", 3'h7, 3'h7, 1'b1, 3'h0);
		mv(1'b1, 4'hf, CRN_SEL, CRM_SEL, OPC2_MOVR, 32'hffff_ffff, 1'b1, 1'b0);
		mv(1'b0, 4'hf, CRN_SEL, CRM_SEL, OPC2_MOVR, 32'h0, 1'b1, 1'b0);
		chk("movr rd", MOVR_WMASK, rd);
		ov("ovr ns", 3'h7, 3'h7, 1'b1, 3'h7);
		ov("ovr sec", 3'h7, 3'h7, 1'b0, 3'h0);
		ov("ovr route", 3'h7, 3'h5, 1'b1, 3'h5);
		ov("ovr route2", 3'h7, 3'h2, 1'b1, 3'h2);
		ov("unmasked", 3'h0, 3'h0, 1'b0, 3'h7);
	endtask

	// reset in mid-run: unmasked takes and the access, override, lock and coherency controls must fall back
	task automatic t_rereset;
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("take rst", 32'h0, {29'h0, take_async_abort, take_irq, take_fiq});
		rst_n = 1'b1;
		t_reset();
		chk("coh rst", 32'h0, {31'h0, coherency_participation_bit});
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// the whole sequence needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		t_reset();
		t_refused();
		t_nsac();
		t_permit();
		t_force();
		t_movr();
		t_rereset();
		end_of_test();
	end
endmodule
